// [logic/trbs_pkg.sv]
// Shared constants and carrier types for the triple rail bias sequencer
package trbs_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF, ST_UP_PRI, ST_UP_NEG, ST_ON, ST_DN_HIGH, ST_DN_NEG
  } trbs_state_t;

  // Primary pump boost ratio codes
  typedef enum logic [1:0] {
    RATIO_X1P00, RATIO_X1P33, RATIO_X1P50, RATIO_X2P00
  } trbs_ratio_t;

  // Variant selector for the high positive rail ratio
  localparam logic HIGH_RATIO_X3 = 1'b0;
  localparam logic HIGH_RATIO_X2 = 1'b1;

  // Rail comparator flags
  typedef struct packed {
    logic priUp;    // Primary at or above 75 percent
    logic negUp;    // Negative at or above 75 percent
    logic highLow;  // High positive at or below 70 percent
    logic negLow;   // Negative at or below 70 percent
  } trbs_rail_flags_t;

  // Pump enables
  typedef struct packed {
    logic pri;
    logic neg;
    logic high;
  } trbs_pump_en_t;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int PUMP_MAX_KHZ = 400;
  localparam int PUMP_PERIOD_CYC = (CLK_MHZ * 1000) / PUMP_MAX_KHZ;
  localparam int DIV_W = 10;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PUMP_PERIOD_CYC - 1);
  localparam logic [1:0] RATIO_RESET = 2'h0;
endpackage

// [logic/trbs_pump_clk.sv]
// Pulse-skipping pump clock gate, at most one pulse per 400 kHz period
`timescale 1ns/1ps
`default_nettype none
module trbs_pump_clk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic pumpEn,
  input wire logic needCharge,
  output logic pumpPulse
);
  logic pulse_q;
  logic pulse_d;

  // R12 skip when regulated
  assign pulse_d = tick && pumpEn && needCharge;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  assign pumpPulse = pulse_q;
endmodule
`default_nettype wire

// [logic/trbs_sequencer.sv]
// Top of the triple rail bias sequencer: power order, ratio choice, pump clocks
// Behaviour
// R01 - Enable low forces full shutdown
// R02 - Undervoltage flag inhibits any converter start
// R03 - Enable rise starts primary pump only
// R04 - Negative pump after primary reaches 75%
// R05 - High pump after negative reaches 75%
// R06 - Enable fall drops high pump first
// R07 - Negative off after high falls 70%
// R08 - Primary off after negative falls 70%
// R09 - Same reverse order on input collapse
// R10 - Primary ratio chosen from input bands
// R11 - Hysteresis between adjacent ratio bands
// R12 - Primary pump pulse-skips up to 400kHz
// R13 - High pump skips, ratio fixed by variant
// R14 - Negative pump inverts, skips, 400kHz max
// R15 - Host must never leave enable floating
// R16 - Shutdown or undervoltage returns to off
`timescale 1ns/1ps
`default_nettype none
module trbs_sequencer #(
  parameter logic HIGH_RATIO_SEL = trbs_pkg::HIGH_RATIO_X3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic powerEn,
  input wire logic uvLow,
  input wire trbs_pkg::trbs_rail_flags_t railFlags,
  input wire logic [2:0] bandUp,
  input wire logic [2:0] bandDown,
  input wire trbs_pkg::trbs_pump_en_t needCharge,
  output trbs_pkg::trbs_pump_en_t pumpEn,
  output trbs_pkg::trbs_pump_en_t pumpPulse,
  output trbs_pkg::trbs_ratio_t priRatio,
  output logic highRatioX2,
  output logic negInvert,
  output logic biasActive
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Analog flags arrive asynchronously; two stages before any use.
  localparam int SYNC_W = 1 + 1 + 4 + 3 + 3 + 3;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic enS;
  logic uvS;
  trbs_pkg::trbs_rail_flags_t flagS;
  logic [2:0] upS;
  logic [2:0] dnS;
  trbs_pkg::trbs_pump_en_t needS;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {powerEn, uvLow, railFlags, bandUp, bandDown, needCharge};
      sync_q <= meta_q;
    end
  end

  assign {enS, uvS, flagS, upS, dnS, needS} = sync_q;

  // ----------------------------------------
  // Power sequencing
  // ----------------------------------------
  trbs_pkg::trbs_state_t state_q;
  trbs_pkg::trbs_state_t state_d;
  logic runOk;

  // R01 enable gating
  // R02 undervoltage lockout
  assign runOk = enS && !uvS;

  always_comb begin
    state_d = state_q;
    case (state_q)
      trbs_pkg::ST_OFF: begin
        // R03 primary first
        if (runOk) begin
          state_d = trbs_pkg::ST_UP_PRI;
        end
      end
      trbs_pkg::ST_UP_PRI: begin
        if (!runOk) begin
          state_d = trbs_pkg::ST_DN_NEG;
        end else if (flagS.priUp) begin
          // R04 negative after primary
          state_d = trbs_pkg::ST_UP_NEG;
        end
      end
      trbs_pkg::ST_UP_NEG: begin
        if (!runOk) begin
          state_d = trbs_pkg::ST_DN_HIGH;
        end else if (flagS.negUp) begin
          // R05 high rail last
          state_d = trbs_pkg::ST_ON;
        end
      end
      trbs_pkg::ST_ON: begin
        // R06 high off first
        // R09 collapse uses same order
        if (!runOk) begin
          state_d = trbs_pkg::ST_DN_HIGH;
        end
      end
      trbs_pkg::ST_DN_HIGH: begin
        // R07 negative after high falls
        if (flagS.highLow) begin
          state_d = trbs_pkg::ST_DN_NEG;
        end
      end
      trbs_pkg::ST_DN_NEG: begin
        // R08 primary last
        // R16 back to all off
        if (flagS.negLow) begin
          state_d = trbs_pkg::ST_OFF;
        end
      end
      default: begin
        state_d = trbs_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= trbs_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Power-down does not abort halfway: rails already up are walked down in
  // order even if enable returns, then a fresh power-up follows.
  trbs_pkg::trbs_pump_en_t en_d;
  // One assignment keeps the enable word to a single driver
  assign en_d = '{
    pri: (state_q != trbs_pkg::ST_OFF),
    neg: (state_q == trbs_pkg::ST_UP_NEG) || (state_q == trbs_pkg::ST_ON)
         || (state_q == trbs_pkg::ST_DN_HIGH),
    high: (state_q == trbs_pkg::ST_ON)
  };

  // ----------------------------------------
  // Primary ratio selection
  // ----------------------------------------
  // bandUp[i]/bandDown[i]: input below lower/upper edge of band boundary i.
  trbs_pkg::trbs_ratio_t ratio_q;
  trbs_pkg::trbs_ratio_t ratio_d;
  logic [1:0] ratioIdx;
  logic raiseReq;
  logic lowerReq;

  assign ratioIdx = ratio_q;
  // R10 raise ratio as input falls
  assign raiseReq = (ratioIdx != 2'h3) && upS[ratioIdx];
  // R11 only leave band past far edge
  assign lowerReq = (ratioIdx != 2'h0) && !dnS[ratioIdx - 2'h1];

  always_comb begin
    ratio_d = ratio_q;
    if (state_q == trbs_pkg::ST_OFF) begin
      ratio_d = trbs_pkg::trbs_ratio_t'(trbs_pkg::RATIO_RESET);
    end else if (raiseReq) begin
      ratio_d = trbs_pkg::trbs_ratio_t'(ratioIdx + 2'h1);
    end else if (lowerReq) begin
      ratio_d = trbs_pkg::trbs_ratio_t'(ratioIdx - 2'h1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ratio_q <= trbs_pkg::RATIO_X1P00;
    end else begin
      ratio_q <= ratio_d;
    end
  end

  // ----------------------------------------
  // Pump clock divider
  // ----------------------------------------
  logic [trbs_pkg::DIV_W-1:0] div_q;
  logic tick;
  assign tick = (div_q == trbs_pkg::DIV_LAST);

  // R01 oscillator stopped in shutdown
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (!en_d.pri || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  logic pulsePri;
  logic pulseNeg;
  logic pulseHigh;

  // R12 primary skip clock
  trbs_pump_clk uPri (
    .sys_clk(sys_clk), .rst_n(rst_n), .tick(tick),
    .pumpEn(en_d.pri), .needCharge(needS.pri), .pumpPulse(pulsePri)
  );
  // R14 negative skip clock
  trbs_pump_clk uNeg (
    .sys_clk(sys_clk), .rst_n(rst_n), .tick(tick),
    .pumpEn(en_d.neg), .needCharge(needS.neg), .pumpPulse(pulseNeg)
  );
  // R13 high rail skip clock
  trbs_pump_clk uHigh (
    .sys_clk(sys_clk), .rst_n(rst_n), .tick(tick),
    .pumpEn(en_d.high), .needCharge(needS.high), .pumpPulse(pulseHigh)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  trbs_pkg::trbs_pump_en_t pumpEn_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pumpEn_q <= '0;
    end else begin
      pumpEn_q <= en_d;
    end
  end

  assign pumpEn = pumpEn_q;
  assign pumpPulse = {pulsePri, pulseNeg, pulseHigh};
  assign priRatio = ratio_q;
  // R13 variant ratio
  assign highRatioX2 = (HIGH_RATIO_SEL == trbs_pkg::HIGH_RATIO_X2);
  // R14 fixed inverting ratio
  assign negInvert = 1'b1;
  assign biasActive = (state_q != trbs_pkg::ST_OFF);
endmodule
`default_nettype wire

// [testbench/trbs_host_model.sv]
// Host-side model that drives the sequencer enable
`timescale 1ns/1ps
`default_nettype none
module trbs_host_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req,
  output logic powerEn
);
  // enable held at a defined level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) powerEn <= 1'b0;
    else powerEn <= req;
  end
endmodule
`default_nettype wire

// [testbench/trbs_seq_asserts.sv]
// Port-level assertion checker for the rail sequencer
`timescale 1ns/1ps
`default_nettype none
module trbs_seq_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic powerEn,
  input wire logic uvLow,
  input wire trbs_pkg::trbs_rail_flags_t railFlags,
  input wire trbs_pkg::trbs_pump_en_t pumpEn,
  input wire trbs_pkg::trbs_pump_en_t pumpPulse,
  input wire trbs_pkg::trbs_ratio_t priRatio,
  input wire logic biasActive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  int pulseGap_q;
  // Saturates so a long idle spell never wraps into a short gap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pulseGap_q <= 1000;
    else if (pumpPulse.pri) pulseGap_q <= 0;
    else if (pulseGap_q < 1000) pulseGap_q <= pulseGap_q + 1;
  end
  sequence s_enSeen;
    $past(powerEn, 3) && !$past(uvLow, 3);
  endsequence
  a_start_needs_en: assert property ($rose(biasActive) |-> s_enSeen)
    else $error("start without enable");
  a_off_quiet: assert property (!biasActive && !$past(biasActive) |-> pumpEn == 3'h0)
    else $error("pump on while off");
  a_pri_first: assert property ($rose(pumpEn.pri) |-> pumpEn == 3'h4)
    else $error("primary not alone");
  a_neg_after_pri: assert property ($rose(pumpEn.neg) |-> $past(railFlags.priUp, 4))
    else $error("negative too early");
  a_high_last: assert property ($rose(pumpEn.high) |-> $past(railFlags.negUp, 4))
    else $error("high too early");
  a_high_off_first: assert property ($fell(pumpEn.high) |-> pumpEn == 3'h6)
    else $error("high not first off");
  a_neg_off_order: assert property ($fell(pumpEn.neg) |-> $past(railFlags.highLow, 4))
    else $error("negative off early");
  a_pri_off_last: assert property ($fell(pumpEn.pri) |-> pumpEn == 3'h0)
    else $error("primary not last");
  a_ratio_step: assert property (biasActive && $past(biasActive) && $changed(priRatio) |->
    2'(priRatio - $past(priRatio)) inside {2'h1, 2'h3})
    else $error("ratio jumped");
  a_pulse_spacing: assert property (pumpPulse.pri |-> pulseGap_q >= 624)
    else $error("pulses too close");
endmodule
bind trbs_sequencer trbs_seq_asserts i_trbs_seq_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
  .powerEn(powerEn), .uvLow(uvLow), .railFlags(railFlags), .pumpEn(pumpEn),
  .pumpPulse(pumpPulse), .priRatio(priRatio), .biasActive(biasActive));
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the rail sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic uvLow = 1'b0;
  logic powerEn, hiX2, negInv, active;
  logic [2:0] bandUp = 3'h0;
  logic [2:0] bandDown = 3'h0;
  trbs_pkg::trbs_rail_flags_t flags = 4'h0;
  trbs_pkg::trbs_pump_en_t need = 3'h0;
  trbs_pkg::trbs_pump_en_t pumpEn, pulse;
  trbs_pkg::trbs_ratio_t ratio;
  int bad_count = 0;
  int comparisons = 0;
  always #2 sys_clk = ~sys_clk;
  trbs_host_model i_trbs_host_model (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
    .powerEn(powerEn));
  trbs_sequencer i_trbs_sequencer (.sys_clk(sys_clk), .rst_n(rst_n), .powerEn(powerEn),
    .uvLow(uvLow), .railFlags(flags), .bandUp(bandUp), .bandDown(bandDown),
    .needCharge(need), .pumpEn(pumpEn), .pumpPulse(pulse), .priRatio(ratio),
    .highRatioX2(hiX2), .negInvert(negInv), .biasActive(active));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_en(input int b, input logic v);
    int i = 0;
    do begin
      cyc(1);
      i++;
    end while (pumpEn[b] !== v && i < 60);
  endtask
  task automatic power_up();
    @(posedge sys_clk);
    req <= 1'b1;
    uvLow <= 1'b0;
    flags <= 4'h0;
    wait_en(2, 1'b1);
    cyc(20);
    check(pumpEn, 4'h4);
    @(posedge sys_clk);
    flags <= 4'h8;
    wait_en(1, 1'b1);
    cyc(20);
    check(pumpEn, 4'h6);
    @(posedge sys_clk);
    flags <= 4'hc;
    wait_en(0, 1'b1);
    check({pumpEn, negInv}, 4'hf);
    check({3'h0, hiX2}, 4'h0);
  endtask
  task automatic power_down(input logic viaUv);
    @(posedge sys_clk);
    if (viaUv) uvLow <= 1'b1;
    else req <= 1'b0;
    wait_en(0, 1'b0);
    cyc(20);
    check(pumpEn, 4'h6);
    @(posedge sys_clk);
    flags <= 4'h2;
    wait_en(1, 1'b0);
    cyc(20);
    check(pumpEn, 4'h4);
    @(posedge sys_clk);
    flags <= 4'h3;
    wait_en(2, 1'b0);
    cyc(2);
    check({pumpEn, active}, 4'h0);
  endtask
  task automatic idle_off();
    @(posedge sys_clk);
    flags <= 4'hc;
    need <= 3'h7;
    cyc(40);
    check({pumpEn, active}, 4'h0);
  endtask
  task automatic bands(input logic [2:0] up, input logic [2:0] dn, input logic [1:0] want);
    @(posedge sys_clk);
    bandUp <= up;
    bandDown <= dn;
    cyc(10);
    check(ratio, want);
  endtask
  task automatic pulse_rate();
    int cnt[3] = '{0, 0, 0};
    repeat (1250) begin
      cyc(1);
      foreach (cnt[k]) cnt[k] += pulse[k];
    end
    check(cnt[2][3:0], 4'h2);
    check(cnt[0][3:0], 4'h2);
    check(cnt[1][3:0], 4'h2);
    // Light load on the primary: every primary pulse is skipped
    @(posedge sys_clk);
    need <= 3'h3;
    cyc(4);
    cnt = '{0, 0, 0};
    repeat (1250) begin
      cyc(1);
      foreach (cnt[k]) cnt[k] += pulse[k];
    end
    check(cnt[2][3:0], 4'h0);
    check(cnt[1][3:0], 4'h2);
    @(posedge sys_clk);
    need <= 3'h7;
  endtask
  task automatic uv_hold();
    cyc(20);
    check({pumpEn, active}, 4'h0);
  endtask
  // Enable drops while the negative rail is still coming up
  task automatic abort_up();
    @(posedge sys_clk);
    req <= 1'b1;
    uvLow <= 1'b0;
    flags <= 4'h0;
    wait_en(2, 1'b1);
    @(posedge sys_clk);
    flags <= 4'h8;
    wait_en(1, 1'b1);
    check(pumpEn, 4'h6);
    power_down(1'b0);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    idle_off();
    power_up();
    bands(3'h1, 3'h1, 2'h1);
    bands(3'h7, 3'h7, 2'h3);
    bands(3'h0, 3'h7, 2'h3);
    bands(3'h0, 3'h3, 2'h2);
    bands(3'h0, 3'h0, 2'h0);
    pulse_rate();
    power_down(1'b0);
    power_up();
    power_down(1'b1);
    uv_hold();
    abort_up();
    power_up();
    end_sim();
  end
  // Run needs under 4000 cycles; 10000 means a hang
  initial begin
    #40000;
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
